// File: hdl/fdcr_pkg.sv
package fdcr_pkg;

  // serial bus address and register offsets
  localparam logic [6:0] FDCR_DEV_ADDR = 7'h30;
  localparam logic [7:0] REG_ID        = 8'h00;
  localparam logic [7:0] REG_PIN       = 8'h02;
  localparam logic [7:0] REG_CUR       = 8'h03;
  localparam logic [7:0] REG_MODE      = 8'h04;

  // identification value, arbitrary
  localparam logic [7:0] FDCR_ID_DEFAULT = 8'h5a;

  // reset values
  localparam logic [7:0] PIN_RST  = 8'h0f;
  localparam logic [7:0] CUR_RST  = 8'h73;
  localparam logic [7:0] MODE_RST = 8'ha4;

  // field codes
  localparam logic [1:0] LM_STANDBY = 2'h0;
  localparam logic [1:0] LM_BOOST_OUTPUT    = 2'h1;
  localparam logic [1:0] LM_ASSIST  = 2'h2;
  localparam logic [1:0] LM_FLASH   = 2'h3;
  localparam logic [1:0] AUXA_TORCH = 2'h1;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  // timing: clock period and one millisecond, in ns
  localparam int unsigned CLK_NS          = 50;
  localparam int unsigned MS_NS           = 1000000;
  localparam int unsigned FDCR_CYC_PER_MS = MS_NS / CLK_NS;

  // pin configuration and flash timer layout
  typedef struct packed {
    logic [1:0] aux_pin_b_function;  // 7:6
    logic [1:0] aux_pin_a_function;  // 5:4
    logic [3:0] flash_duration_code; // 3:0
  } fdcr_pin_cfg_t;

  // led current layout
  typedef struct packed {
    logic [4:0] flash_current_code;  // 7:3
    logic [2:0] torch_current_code;  // 2:0
  } fdcr_cur_cfg_t;

  // output mode layout
  typedef struct packed {
    logic [1:0] inductor_peak_limit;     // 7:6
    logic       trigger_level_select;    // 5
    logic       switch_freq_fallback_en; // 4
    logic       output_en;               // 3
    logic       trigger_source_select;   // 2
    logic [1:0] light_output_mode;       // 1:0
  } fdcr_mode_cfg_t;

  // serial slave states
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_SUB, I2C_SUB_ACK,
    I2C_WR, I2C_WR_ACK, I2C_RD, I2C_RD_ACK
  } fdcr_i2c_st_t;

  // flash sequencer states
  typedef enum logic {
    FL_IDLE, FL_ON
  } fdcr_fl_st_t;

  // flash duration in ms from its code
  function automatic logic [10:0] fdcr_flash_ms(input logic [3:0] code);
    logic [10:0] ms;
    ms = 11'd1600;
    case (code)
      4'h0: ms = 11'd100;
      4'h1: ms = 11'd200;
      4'h2: ms = 11'd300;
      4'h3: ms = 11'd400;
      4'h4: ms = 11'd500;
      4'h5: ms = 11'd600;
      4'h6: ms = 11'd700;
      4'h7: ms = 11'd800;
      4'h8: ms = 11'd900;
      4'h9: ms = 11'd1100;
      4'hb: ms = 11'd1200;
      4'hd: ms = 11'd1200;
      4'hc: ms = 11'd1300;
      4'he: ms = 11'd1500;
      default: ms = 11'd1600; // 1111 and unlisted 1010
    endcase
    return ms;
  endfunction

endpackage

// File: hdl/fdcr_sync.sv
`timescale 1ns/1ps
// three stage pin filter; output moves when stages two and three agree
module fdcr_sync #(
  parameter logic RST_VAL = 1'b0  // level held in reset
) (
  input  wire logic mclk,   // system clock
  input  wire logic rst_n,  // sync reset, active low
  input  wire logic ce,     // clock enable
  input  wire logic pin,    // asynchronous input
  output logic      q       // filtered level
);
  logic s1_q;  // metastable stage, read by s2 only
  logic s2_q;  // second stage
  logic s3_q;  // third stage

  // shift chain and agreement filter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q    <= RST_VAL;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule // fdcr_sync

// File: hdl/fdcr_top.sv
`timescale 1ns/1ps
// flash driver register bank behind a two wire serial slave
module fdcr_top import fdcr_pkg::*; #(
  parameter logic [7:0]  ID_CODE    = FDCR_ID_DEFAULT, // arbitrary value
  parameter int unsigned CYC_PER_MS = FDCR_CYC_PER_MS  // cycles per ms
) (
  input  wire logic      mclk,            // 20 MHz clock
  input  wire logic      rst_n,           // sync reset, power on
  input  wire logic      ce,              // clock enable
  input  wire logic      scl,             // serial clock pin
  input  wire logic      sda_in,          // serial data pin level
  output logic           sda_out,         // serial data drive value
  output logic           sda_oe,          // serial data drive enable
  input  wire logic      en_pin,          // device enable pin
  input  wire logic      strobe_pin,      // flash trigger pin
  input  wire logic      aux_pin_a,       // aux pin a level
  input  wire logic      crit_fault,      // critical fault, same clock
  input  wire logic      fault_clear,     // fault clear pulse
  output fdcr_pin_cfg_t  pin_cfg_q,       // pin config and timer
  output fdcr_cur_cfg_t  cur_cfg_q,       // led current codes
  output fdcr_mode_cfg_t mode_cfg_q,      // output mode control
  output logic           flash_on_q,      // flash current source on
  output logic           assist_on_q,     // torch or assist current on
  output logic           boost5v_on_q,    // fixed 5 v regulation on
  output logic           timeout_fault_q  // flash timeout fault
);

  localparam int PW = $clog2(CYC_PER_MS + 1);  // prescaler width

  // filtered pins
  logic scl_s;     // filtered clock
  logic sda_s;     // filtered data
  logic en_s;      // filtered enable
  logic strobe_s;  // filtered trigger
  logic torch_s;   // filtered aux pin a

  // one cycle old copies for edge detection
  logic scl_d_q;
  logic sda_d_q;
  logic en_d_q;
  logic strobe_d_q;

  // edge and bus condition terms
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic en_rise;
  logic strobe_rise;

  // serial slave state
  fdcr_i2c_st_t st_q;      // protocol state
  logic [3:0]   bit_cnt_q; // bits of current byte
  logic [7:0]   shift_q;   // byte shifter
  logic [7:0]   ptr_q;     // register pointer
  logic         rnw_q;     // read transfer
  logic         nack_q;    // master refused next byte
  logic [7:0]   rd_data;   // register read mux
  logic         wr_stb;    // data byte complete

  // flash sequencer state
  fdcr_fl_st_t  fl_q;      // sequencer state
  logic [PW-1:0] pre_q;    // ms prescaler
  logic [10:0]  ms_q;      // elapsed ms
  logic [10:0]  dur_ms;    // programmed duration
  logic         ms_tick;   // one ms passed
  logic         fire_ok;   // flash allowed
  logic         fl_start;  // begin a flash
  logic         fl_end;    // duration reached
  logic         fl_tout;   // level trigger overran
  logic         sw_done;   // software flash finished
  logic         lvl_hw;    // hardware level trigger mode

  // pin filters
  fdcr_sync #(.RST_VAL(1'b1)) u_scl (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (scl),
    .q     (scl_s)
  );
  fdcr_sync #(.RST_VAL(1'b1)) u_sda (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (sda_in),
    .q     (sda_s)
  );
  fdcr_sync #(.RST_VAL(1'b0)) u_en (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (en_pin),
    .q     (en_s)
  );
  fdcr_sync #(.RST_VAL(1'b0)) u_strobe (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (strobe_pin),
    .q     (strobe_s)
  );
  fdcr_sync #(.RST_VAL(1'b0)) u_torch (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (aux_pin_a),
    .q     (torch_s)
  );

  // previous filtered levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_d_q    <= 1'b1;
      sda_d_q    <= 1'b1;
      en_d_q     <= 1'b0;
      strobe_d_q <= 1'b0;
    end else if (ce) begin
      scl_d_q    <= scl_s;
      sda_d_q    <= sda_s;
      en_d_q     <= en_s;
      strobe_d_q <= strobe_s;
    end
  end

  // edges; start and stop are data moves while clock high
  assign scl_rise    = scl_s & ~scl_d_q;
  assign scl_fall    = ~scl_s & scl_d_q;
  assign bus_start   = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign bus_stop    = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign en_rise     = en_s & ~en_d_q;
  assign strobe_rise = strobe_s & ~strobe_d_q;

  // data byte lands on the falling clock after its eighth bit
  assign wr_stb = scl_fall & ~bus_start & ~bus_stop &
                  (st_q == I2C_WR) & (bit_cnt_q == BYTE_BITS);

  // read mux; unmapped offsets read zero
  always_comb begin
    case (ptr_q)
      REG_ID:   rd_data = ID_CODE;
      REG_PIN:  rd_data = pin_cfg_q;
      REG_CUR:  rd_data = cur_cfg_q;
      REG_MODE: rd_data = mode_cfg_q;
      default:  rd_data = 8'h00;
    endcase
  end

  // serial slave protocol engine
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q      <= I2C_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      rnw_q     <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (ce) begin
      if (bus_start) begin
        // start or repeated start: expect address
        st_q      <= I2C_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        st_q   <= I2C_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        // msb first, sampled on rising clock
        unique case (st_q)
          I2C_ADDR, I2C_SUB, I2C_WR: begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          I2C_RD_ACK: begin
            nack_q <= sda_s;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        // drive and advance on falling clock
        unique case (st_q)
          I2C_ADDR: begin
            if (bit_cnt_q == BYTE_BITS) begin
              if (shift_q[7:1] == FDCR_DEV_ADDR) begin
                st_q   <= I2C_ADDR_ACK;
                rnw_q  <= shift_q[0];
                sda_oe <= 1'b1;
              end else begin
                st_q <= I2C_IDLE;
              end
            end
          end
          I2C_ADDR_ACK: begin
            if (rnw_q) begin
              // first read byte, msb out now
              st_q      <= I2C_RD;
              shift_q   <= rd_data;
              sda_oe    <= ~rd_data[7];
              bit_cnt_q <= 4'h1;
            end else begin
              st_q      <= I2C_SUB;
              sda_oe    <= 1'b0;
              bit_cnt_q <= 4'h0;
            end
          end
          I2C_SUB: begin
            if (bit_cnt_q == BYTE_BITS) begin
              st_q   <= I2C_SUB_ACK;
              sda_oe <= 1'b1;
            end
          end
          I2C_WR: begin
            if (bit_cnt_q == BYTE_BITS) begin
              st_q   <= I2C_WR_ACK;
              sda_oe <= 1'b1;
            end
          end
          I2C_SUB_ACK, I2C_WR_ACK: begin
            st_q      <= I2C_WR;
            sda_oe    <= 1'b0;
            bit_cnt_q <= 4'h0;
          end
          I2C_RD: begin
            if (bit_cnt_q == BYTE_BITS) begin
              // release for master acknowledge
              st_q   <= I2C_RD_ACK;
              sda_oe <= 1'b0;
            end else begin
              shift_q   <= {shift_q[6:0], 1'b0};
              sda_oe    <= ~shift_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          I2C_RD_ACK: begin
            if (nack_q) begin
              st_q <= I2C_IDLE;
            end else begin
              // next register, pointer already advanced
              st_q      <= I2C_RD;
              shift_q   <= rd_data;
              sda_oe    <= ~rd_data[7];
              bit_cnt_q <= 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge mclk) begin
    sda_out <= 1'b0;
  end

  // register pointer: loaded by subaddress, steps after each data byte
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ptr_q <= 8'h00;
    end else if (ce && scl_fall && !bus_start && !bus_stop) begin
      if (st_q == I2C_SUB && bit_cnt_q == BYTE_BITS) begin
        ptr_q <= shift_q;
      end else if (wr_stb) begin
        ptr_q <= ptr_q + 8'h01;
      end else if (st_q == I2C_RD && bit_cnt_q == BYTE_BITS) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // register bank
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_cfg_q  <= PIN_RST;
      cur_cfg_q  <= CUR_RST;
      mode_cfg_q <= MODE_RST;
    end else if (ce) begin
      if (en_rise) begin
        pin_cfg_q  <= PIN_RST;
        cur_cfg_q  <= CUR_RST;
        mode_cfg_q <= MODE_RST;
      end else begin
        if (wr_stb) begin
          case (ptr_q)
            REG_PIN:  pin_cfg_q  <= shift_q;
            REG_CUR:  cur_cfg_q  <= shift_q;
            REG_MODE: mode_cfg_q <= shift_q;
            default: begin
            end
          endcase
        end
        if (crit_fault || fl_tout || sw_done) begin
          mode_cfg_q.output_en <= 1'b0;
        end
      end
    end
  end

  assign dur_ms = fdcr_flash_ms(pin_cfg_q.flash_duration_code);

  // output on, flash mode, no fault
  assign fire_ok = en_s & mode_cfg_q.output_en & ~timeout_fault_q &
                   (mode_cfg_q.light_output_mode == LM_FLASH);
  assign lvl_hw  = mode_cfg_q.trigger_source_select &
                   mode_cfg_q.trigger_level_select;

  always_comb begin
    if (!mode_cfg_q.trigger_source_select) begin
      fl_start = fire_ok;
    end else if (mode_cfg_q.trigger_level_select) begin
      fl_start = fire_ok & strobe_s;
    end else begin
      fl_start = fire_ok & strobe_rise;
    end
  end

  assign ms_tick = (fl_q == FL_ON) && (pre_q == PW'(CYC_PER_MS - 1));
  assign fl_end  = ms_tick && (ms_q == dur_ms - 11'd1);
  assign fl_tout = fl_end & lvl_hw & strobe_s;
  assign sw_done = fl_end & ~mode_cfg_q.trigger_source_select;

  // flash sequencer and ms timer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fl_q       <= FL_IDLE;
      pre_q      <= '0;
      ms_q       <= 11'd0;
      flash_on_q <= 1'b0;
    end else if (ce) begin
      unique case (fl_q)
        FL_IDLE: begin
          pre_q <= '0;
          ms_q  <= 11'd0;
          if (fl_start) begin
            fl_q       <= FL_ON;
            flash_on_q <= 1'b1;
          end
        end
        FL_ON: begin
          if (!fire_ok || fl_end || (lvl_hw && !strobe_s)) begin
            // enable lost, duration over or trigger released
            fl_q       <= FL_IDLE;
            flash_on_q <= 1'b0;
          end else if (ms_tick) begin
            pre_q <= '0;
            ms_q  <= ms_q + 11'd1;
          end else begin
            pre_q <= pre_q + PW'(1);
          end
        end
      endcase
    end
  end

  // timeout fault: a set in the clear cycle wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timeout_fault_q <= 1'b0;
    end else if (ce) begin
      if (fl_tout) begin
        timeout_fault_q <= 1'b1;
      end else if (fault_clear) begin
        timeout_fault_q <= 1'b0;
      end
    end
  end

  // steady drive modes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      assist_on_q  <= 1'b0;
      boost5v_on_q <= 1'b0;
    end else if (ce) begin
      // assist mode, or torch pin in standby mode when aux a is torch
      assist_on_q <= en_s & mode_cfg_q.output_en &
                     ((mode_cfg_q.light_output_mode == LM_ASSIST) |
                      ((pin_cfg_q.aux_pin_a_function == AUXA_TORCH) &
                       torch_s &
                       (mode_cfg_q.light_output_mode == LM_STANDBY)));
      boost5v_on_q <= en_s & mode_cfg_q.output_en &
                      (mode_cfg_q.light_output_mode == LM_BOOST_OUTPUT);
    end
  end

endmodule // fdcr_top

// File: testbench/fdcr_monitor.sv
`timescale 1ns/1ps
// property checker beside the register bank
module fdcr_monitor import fdcr_pkg::*; #(
  parameter int unsigned CYC_PER_MS = 10  // cycles per ms
) (
  input wire logic      mclk,            // clock
  input wire logic      rst_n,           // sync reset
  input wire logic      ce,              // clock enable
  input wire logic      crit_fault,      // critical fault
  input wire logic      fault_clear,     // fault clear
  input fdcr_pin_cfg_t  pin_cfg_q,       // pins and timer
  input fdcr_cur_cfg_t  cur_cfg_q,       // currents
  input fdcr_mode_cfg_t mode_cfg_q,      // output mode
  input wire logic      flash_on_q,      // flash on
  input wire logic      assist_on_q,     // assist on
  input wire logic      boost5v_on_q,    // 5 v on
  input wire logic      timeout_fault_q  // timeout fault
);
  localparam int LEN0 = 100 * CYC_PER_MS; // shortest flash
  logic [31:0] run_q;                     // cycles flash has been on

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // count consecutive flash cycles
  always_ff @(posedge mclk) begin
    if (!rst_n || !flash_on_q) begin
      run_q <= 32'h0;
    end else if (ce) begin
      run_q <= run_q + 32'h1;
    end
  end

  property p_rst_vals;
    $rose(rst_n) |-> pin_cfg_q == 8'h0f && cur_cfg_q == 8'h73
      && mode_cfg_q == 8'ha4;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("defaults wrong after reset");

  property p_crit_clr;
    ce && crit_fault |=> !mode_cfg_q.output_en;
  endproperty
  a_crit_clr: assert property (p_crit_clr)
    else $error("output enable kept after fault");

  property p_fl_mode;
    $rose(flash_on_q) |-> $past(mode_cfg_q.output_en)
      && $past(mode_cfg_q.light_output_mode) == LM_FLASH;
  endproperty
  a_fl_mode: assert property (p_fl_mode)
    else $error("flash outside flash mode");

  property p_sw_fire;
    ce && $rose(mode_cfg_q.output_en) && !crit_fault && !timeout_fault_q
      && mode_cfg_q.light_output_mode == LM_FLASH
      && !mode_cfg_q.trigger_source_select |=> flash_on_q;
  endproperty
  a_sw_fire: assert property (p_sw_fire)
    else $error("software flash did not fire");

  property p_boost;
    $rose(boost5v_on_q) |-> mode_cfg_q.output_en
      && mode_cfg_q.light_output_mode == LM_BOOST_OUTPUT;
  endproperty
  a_boost: assert property (p_boost)
    else $error("5 v output in wrong mode");

  property p_one_drv;
    $onehot0({flash_on_q, assist_on_q, boost5v_on_q});
  endproperty
  a_one_drv: assert property (p_one_drv)
    else $error("two output modes at once");

  property p_to_lvl;
    $rose(timeout_fault_q) |-> $past(mode_cfg_q.trigger_level_select)
      && $past(mode_cfg_q.trigger_source_select);
  endproperty
  a_to_lvl: assert property (p_to_lvl)
    else $error("timeout outside level trigger");

  property p_to_off;
    $rose(timeout_fault_q) |-> ##[0:1]
      (!mode_cfg_q.output_en && !flash_on_q);
  endproperty
  a_to_off: assert property (p_to_off)
    else $error("driver not shut after timeout");

  property p_clr;
    ce && fault_clear && timeout_fault_q |=> !timeout_fault_q;
  endproperty
  a_clr: assert property (p_clr)
    else $error("timeout fault not cleared");

  property p_fl_len;
    flash_on_q && pin_cfg_q.flash_duration_code == 4'h0 |-> run_q <= LEN0;
  endproperty
  a_fl_len: assert property (p_fl_len)
    else $error("flash longer than timer");
endmodule // fdcr_monitor

bind fdcr_top fdcr_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .crit_fault(crit_fault),
  .fault_clear(fault_clear), .pin_cfg_q(pin_cfg_q),
  .cur_cfg_q(cur_cfg_q), .mode_cfg_q(mode_cfg_q),
  .flash_on_q(flash_on_q), .assist_on_q(assist_on_q),
  .boost5v_on_q(boost5v_on_q), .timeout_fault_q(timeout_fault_q));

// File: testbench/fdcr_host.sv
`timescale 1ns/1ps
// serial bus master in place of the host processor
module fdcr_host (
  input  wire logic mclk,    // system clock
  input  wire logic sda_oe,  // device pulls data low
  input  wire logic sda_out, // device drive value
  output logic      scl,     // serial clock
  output logic      sda_in   // resolved data line
);
  int   half = 8;  // cycles per clock phase
  logic sda_h;     // host data, 1 releases

  // open drain line with pull-up
  assign sda_in = sda_h & ~(sda_oe & ~sda_out);

  // bus idle at time zero
  initial begin
    scl   = 1'b1;
    sda_h = 1'b1;
  end

  // one clock phase
  task automatic hold();
    repeat (half) @(posedge mclk);
  endtask

  // start or repeated start, clock left low
  task automatic start_c();
    hold();
    sda_h <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_h <= 1'b0;
    hold();
    scl <= 1'b0;
  endtask

  // stop, bus released
  task automatic stop_c();
    hold();
    sda_h <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_h <= 1'b1;
  endtask

  // one bit: data set while clock low, sampled at end of high
  task automatic bit_c(input logic d, output logic q);
    hold();
    sda_h <= d;
    hold();
    scl <= 1'b1;
    hold();
    q = sda_in;
    scl <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], q);
    end
    bit_c(1'b1, q);
    ack = !q;
  endtask

  // read a byte, then ack or nack
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, b[i]);
    end
    bit_c(last, q);
  endtask
endmodule // fdcr_host

// File: testbench/tb_flash_driver_control_registers.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); \
  end end
// self checking bench for the register bank
module tb_flash_driver_control_registers import fdcr_pkg::*;;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
  logic           mclk = 1'b0;        // clock
  logic           rst_n = 1'b0;       // reset
  logic           ce = 1'b1;          // clock enable
  logic           en_pin = 1'b1;      // enable pin
  logic           strobe_pin = 1'b0;  // trigger pin
  logic           aux_pin_a = 1'b0;   // torch pin
  logic           crit_fault = 1'b0;  // fault input
  logic           fault_clear = 1'b0; // fault clear
  logic           scl;                // serial clock
  logic           sda_in;             // data line
  logic           sda_oe;             // device pull
  logic           sda_out;            // device drive value
  fdcr_pin_cfg_t  pin_cfg_q;          // reg 0x02
  fdcr_cur_cfg_t  cur_cfg_q;          // reg 0x03
  fdcr_mode_cfg_t mode_cfg_q;         // reg 0x04
  logic           flash_on_q;         // flash on
  logic           assist_on_q;        // assist on
  logic           boost5v_on_q;       // 5 v on
  logic           timeout_fault_q;    // timeout fault
  int             n_mismatch = 0;     // mismatches
  int             cmp_count = 0;      // comparisons
  int             run_len = 0;        // current flash length
  int             last_len = 0;       // last flash length
  logic [15:0]    tbl [8] = '{16'h0248, 16'h02a9, 16'h0300, 16'h0470,
                              16'h04d4, 16'h021d, 16'h02de, 16'h03c7};

  fdcr_top #(.ID_CODE(ID_VAL), .CYC_PER_MS(10)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .en_pin(en_pin),
    .strobe_pin(strobe_pin), .aux_pin_a(aux_pin_a),
    .crit_fault(crit_fault), .fault_clear(fault_clear),
    .pin_cfg_q(pin_cfg_q), .cur_cfg_q(cur_cfg_q),
    .mode_cfg_q(mode_cfg_q), .flash_on_q(flash_on_q),
    .assist_on_q(assist_on_q), .boost5v_on_q(boost5v_on_q),
    .timeout_fault_q(timeout_fault_q));

  fdcr_host host (.mclk(mclk), .sda_oe(sda_oe), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out));

  // 20 mhz clock
  always #25 mclk = ~mclk;

  // measure each flash in cycles
  always @(posedge mclk) begin
    if (flash_on_q) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len  <= 0;
    end
  end

  // wait then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    host.start_c();
    host.put_byte(8'h60, k);
    `CHK("ack", 1'b1, k)
    host.put_byte(a, k);
    host.put_byte(d, k);
    host.stop_c();
    cyc(1);
  endtask

  // read via repeated start and 0x61
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic       k;
    logic [7:0] d;
    host.start_c();
    host.put_byte(8'h60, k);
    host.put_byte(a, k);
    host.start_c();
    host.put_byte(8'h61, k);
    host.get_byte(1'b1, d);
    host.stop_c();
    `CHK("reg", e, d)
  endtask

  task automatic pulse_strobe(input int n, input int w);
    @(posedge mclk) strobe_pin <= 1'b1;
    repeat (n) @(posedge mclk);
    strobe_pin <= 1'b0;
    cyc(w);
  endtask

  // verdict and end of run
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic ack;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(8);
    chk_reg(8'h00, ID_VAL);
    chk_reg(8'h02, 8'h0f);
    chk_reg(8'h03, 8'h73);
    chk_reg(8'h04, 8'ha4);
    reg_wr(8'h00, 8'hff);
    chk_reg(8'h00, ID_VAL);
    host.half = 16;
    foreach (tbl[i]) begin
      reg_wr(tbl[i][15:8], tbl[i][7:0]);
      chk_reg(tbl[i][15:8], tbl[i][7:0]);
    end
    host.half = 8;
    `CHK("aux b", 2'h3, pin_cfg_q.aux_pin_b_function)
    `CHK("aux a", 2'h1, pin_cfg_q.aux_pin_a_function)
    `CHK("timer", 4'he, pin_cfg_q.flash_duration_code)
    `CHK("flash i", 5'h18, cur_cfg_q.flash_current_code)
    `CHK("torch i", 3'h7, cur_cfg_q.torch_current_code)
    reg_wr(8'h04, 8'ha9);
    `CHK("boost", 1'b1, boost5v_on_q)
    reg_wr(8'h04, 8'haa);
    `CHK("assist", 1'b1, assist_on_q)
    reg_wr(8'h02, 8'h10);
    reg_wr(8'h04, 8'ha8);
    @(posedge mclk) aux_pin_a <= 1'b1;
    cyc(10);
    `CHK("torch", 1'b1, assist_on_q)
    @(posedge mclk) aux_pin_a <= 1'b0;
    reg_wr(8'h04, 8'haf);
    pulse_strobe(200, 30);
    `CHK("lvl len", 1'b1, last_len inside {[196:204]})
    pulse_strobe(1200, 30);
    `CHK("timeout", 1'b1, timeout_fault_q)
    `CHK("to len", 1'b1, last_len inside {[999:1003]})
    chk_reg(8'h04, 8'ha7);
    @(posedge mclk) fault_clear <= 1'b1;
    @(posedge mclk) fault_clear <= 1'b0;
    cyc(2);
    `CHK("clear", 1'b0, timeout_fault_q)
    reg_wr(8'h04, 8'h8f);
    pulse_strobe(20, 1100);
    `CHK("edge len", 1'b1, last_len inside {[999:1003]})
    chk_reg(8'h04, 8'h8f);
    @(posedge mclk) crit_fault <= 1'b1;
    @(posedge mclk) crit_fault <= 1'b0;
    chk_reg(8'h04, 8'h87);
    reg_wr(8'h04, 8'h8b);
    cyc(1100);
    `CHK("sw len", 1'b1, last_len inside {[999:1002]})
    chk_reg(8'h04, 8'h83);
    @(posedge mclk) en_pin <= 1'b0;
    cyc(20);
    @(posedge mclk) en_pin <= 1'b1;
    cyc(20);
    `CHK("pin dflt", 8'h0f, pin_cfg_q)
    `CHK("cur dflt", 8'h73, cur_cfg_q)
    `CHK("mode dflt", 8'ha4, mode_cfg_q)
    host.start_c();
    host.put_byte(8'h62, ack);
    host.stop_c();
    `CHK("no ack", 1'b0, ack)
    print_verdict();
  end

  // cut a hang short
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
endmodule // tb_flash_driver_control_registers
